// [core/nv_ctrl_pkg.sv]
package nv_ctrl_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int unsigned ARRAY_BYTES  = 512;
    localparam int unsigned ADDR_W       = 9;
    localparam int unsigned BLOCK_BYTES  = 128;
    localparam int unsigned NUM_BLOCKS   = 4;
    localparam int unsigned HALF_BYTES   = 256;
    localparam logic [8:0]  SECURE_LO    = 9'h0F0;
    localparam logic [8:0]  SECURE_HI    = 9'h0FF;
    localparam logic [8:0]  CFG_BYTE_ADR = 9'h1FF;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

    // ----------------------------------------------------------------
    // Avalon map: word index 0..511 array, 512 control, 513 shadow
    // ----------------------------------------------------------------
    localparam logic [9:0]  CTRL_IDX     = 10'h200;
    localparam logic [9:0]  SHADOW_IDX   = 10'h201;

    // Control register fields
    localparam int unsigned CR_SEL_LO    = 0;
    localparam int unsigned CR_SEL_HI    = 1;
    localparam int unsigned CR_LATCH     = 2;
    localparam int unsigned CR_HV        = 3;
    localparam int unsigned CR_PWRDN     = 4;
    localparam int unsigned CR_PUMPCLK   = 5;
    localparam logic [7:0]  CR_RESET     = 8'h00;

    // Configuration byte fields
    localparam int unsigned CB_BP0       = 0;
    localparam int unsigned CB_REDUND    = 4;
    localparam int unsigned CB_CON1      = 5;
    localparam int unsigned CB_CON2      = 6;
    localparam int unsigned CB_LOCK_N    = 7;
    localparam logic [7:0]  CFG_ERASED   = 8'hFF;
    // As-shipped config byte: unlocked, no protection, normal mode.
    // An erased byte would set redundancy, protect blocks 0 and 1 and refuse captures in the upper half, itself included.
    localparam logic [7:0]  CFG_SHIPPED  = 8'hE0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 50;

    typedef enum logic [1:0] {
        OP_PROGRAM     = 2'h0,
        OP_BYTE_ERASE  = 2'h1,
        OP_BLOCK_ERASE = 2'h2,
        OP_BULK_ERASE  = 2'h3
    } op_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARMED = 2'h1,
        ST_HV    = 2'h3
    } hv_state_type;

    typedef struct packed {
        logic [8:0] adr;
        logic [7:0] dat;
    } capture_type;
endpackage : nv_ctrl_pkg

// [core/nv_ctrl.sv]
`timescale 1ns/1ns
module nv_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             pump_on,
    output logic             pump_clk_bus,
    output logic             array_hv,
    output logic [1:0]       mcu_config
);
    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    // Array starts erased, config byte in its shipped state
    logic [7:0]                mem_r [0:511] = '{
        nv_ctrl_pkg::CFG_BYTE_ADR: nv_ctrl_pkg::CFG_SHIPPED,
        default:                   nv_ctrl_pkg::ERASED_BYTE};
    logic [7:0]                ctrl_r;
    logic [7:0]                shadow_r;
    logic                      shadow_ld_r;
    logic                      captured_r;
    logic                      stray_wr_r;
    nv_ctrl_pkg::capture_type  cap_r;
    nv_ctrl_pkg::hv_state_type st_r;
    logic                      ack_r;
    logic [31:0]               rdata_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire        req        = (avs_read | avs_write) & ~ack_r;
    wire        hit_array  = ~avs_address[9];
    wire        hit_ctrl   = avs_address == nv_ctrl_pkg::CTRL_IDX;
    wire        hit_shadow = avs_address == nv_ctrl_pkg::SHADOW_IDX;
    wire [8:0]  badr       = avs_address[8:0];
    wire        redund     = shadow_r[nv_ctrl_pkg::CB_REDUND];
    wire        locked     = ~shadow_r[nv_ctrl_pkg::CB_LOCK_N];
    wire        latch      = ctrl_r[nv_ctrl_pkg::CR_LATCH];
    wire        hv         = ctrl_r[nv_ctrl_pkg::CR_HV];
    wire        pwrdn      = ctrl_r[nv_ctrl_pkg::CR_PWRDN];
    wire [1:0]  op_sel     = ctrl_r[nv_ctrl_pkg::CR_SEL_HI:0];

    wire        secure_hit = locked
                           & (badr >= nv_ctrl_pkg::SECURE_LO)
                           & (badr <= nv_ctrl_pkg::SECURE_HI);
    wire        cfg_hit    = badr == nv_ctrl_pkg::CFG_BYTE_ADR;
    wire        adr_ok     = ~(redund & badr[8]);
    wire        valid_adr  = hit_array & adr_ok & ~secure_hit
                           & ~(locked & cfg_hit);
    wire        wr_go      = req & avs_write;
    wire        rd_go      = req & avs_read;

    wire [1:0]  cap_blk    = cap_r.adr[8:7];
    wire [3:0]  bp_eff     = redund ? {2'h0, shadow_r[1:0]} : shadow_r[3:0];
    wire        any_bp     = |bp_eff;

    wire        cap_prot   = bp_eff[cap_blk];
    wire        op_blocked = cap_prot
                           | ((op_sel == nv_ctrl_pkg::OP_BULK_ERASE)
                              & any_bp)
                           | (locked & op_sel[1]);

    // ----------------------------------------------------------------
    // Control register write filter
    // ----------------------------------------------------------------
    wire [7:0]  wd         = avs_writedata[7:0];
    wire        ctrl_ok    = ~(latch & ~captured_r);
    // high voltage needs latch and capture
    wire        hv_allowed = wd[nv_ctrl_pkg::CR_LATCH] & latch
                           & captured_r & ~op_blocked & ~stray_wr_r;
    wire        hv_nxt     = wd[nv_ctrl_pkg::CR_HV] & hv_allowed;
    wire        latch_nxt  = wd[nv_ctrl_pkg::CR_LATCH] | hv;
    wire [1:0]  sel_nxt    = hv ? op_sel : wd[1:0];
    wire [7:0]  ctrl_nxt   = {2'h0, wd[nv_ctrl_pkg::CR_PUMPCLK],
                              wd[nv_ctrl_pkg::CR_PWRDN], hv_nxt,
                              latch_nxt, sel_nxt};

    wire [7:0]  arr_rd     = latch ? cap_r.dat : mem_r[badr];
    wire [7:0]  rd_byte    = hit_array ? arr_rd
                           : hit_ctrl ? ctrl_r
                           : hit_shadow ? shadow_r : 8'h00;

    // High voltage falling edge performs the operation
    wire        hv_end     = hv & wr_go & hit_ctrl & ~ctrl_nxt[3];

    // ----------------------------------------------------------------
    // Bus slave: one wait cycle, then acknowledge
    // ----------------------------------------------------------------
    assign avs_waitrequest = ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= req;
            if (rd_go) begin
                rdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register and capture
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r     <= nv_ctrl_pkg::CR_RESET;
            captured_r <= 1'b0;
            stray_wr_r <= 1'b0;
            cap_r      <= '0;
        end else begin
            if (wr_go & hit_ctrl & ctrl_ok) begin
                ctrl_r <= ctrl_nxt;
            end
            if (wr_go & latch & valid_adr & ~hv) begin
                cap_r      <= '{adr: badr, dat: wd};
                captured_r <= 1'b1;
            end else if (wr_go & hit_ctrl & ctrl_ok & ~latch_nxt) begin
                captured_r <= 1'b0;
            end
            if (wr_go & ~latch & ~valid_adr & ~hit_ctrl) begin
                stray_wr_r <= 1'b1;
            end else if (wr_go & hit_ctrl & ctrl_ok & latch_nxt) begin
                stray_wr_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Array update at end of high-voltage phase
    // ----------------------------------------------------------------
    // apply operation on mirrored copies
    always_ff @(posedge ref_clk) begin
        if (hv_end & ~pwrdn) begin
            for (int i = 0; i < nv_ctrl_pkg::ARRAY_BYTES; i++) begin
                logic [8:0] ia;
                logic       tgt;
                ia  = 9'(i);
                tgt = 1'b0;
                case (op_sel)
                    nv_ctrl_pkg::OP_PROGRAM,
                    nv_ctrl_pkg::OP_BYTE_ERASE: begin
                        tgt = (ia == cap_r.adr)
                            | (redund & (ia == {1'b1, cap_r.adr[7:0]}));
                    end
                    nv_ctrl_pkg::OP_BLOCK_ERASE: begin
                        tgt = (ia[8:7] == cap_blk)
                            | (redund & (ia[8:7] == {1'b1, cap_blk[0]}));
                        tgt = tgt & (ia != nv_ctrl_pkg::CFG_BYTE_ADR);
                    end
                    default: begin
                        tgt = ia != nv_ctrl_pkg::CFG_BYTE_ADR;
                    end
                endcase
                if (tgt) begin
                    if (op_sel == nv_ctrl_pkg::OP_PROGRAM) begin
                        mem_r[i] <= mem_r[i] & cap_r.dat;
                    end else begin
                        mem_r[i] <= nv_ctrl_pkg::ERASED_BYTE;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Shadow configuration
    // ----------------------------------------------------------------
    // reload at reset release and on read
    // lock freezes config byte via valid_adr
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_r    <= nv_ctrl_pkg::CFG_ERASED;
            shadow_ld_r <= 1'b1;
        end else begin
            shadow_ld_r <= 1'b0;
            if (shadow_ld_r | (rd_go & hit_array & cfg_hit & ~latch)) begin
                shadow_r <= mem_r[nv_ctrl_pkg::CFG_BYTE_ADR];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pump control
    // ----------------------------------------------------------------
    // pump and voltage follow hv, gated by power-down
    assign pump_on      = hv & ~pwrdn;
    assign array_hv     = hv & ~pwrdn;
    assign pump_clk_bus = ctrl_r[nv_ctrl_pkg::CR_PUMPCLK];
    assign mcu_config   = {shadow_r[nv_ctrl_pkg::CB_CON2],
                           shadow_r[nv_ctrl_pkg::CB_CON1]};
endmodule : nv_ctrl

// [verification/nv_ctrl_props.sv]
`timescale 1ns/1ns
module nv_ctrl_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        pump_on,
    input wire logic        pump_clk_bus,
    input wire logic        array_hv,
    input wire logic [1:0]  mcu_config
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire ack    = !avs_waitrequest;
    // A request is taken on the edge where waitrequest is still high
    wire ctrl_wr = avs_write && avs_waitrequest
                   && avs_address == nv_ctrl_pkg::CTRL_IDX;
    wire cfg_rd = avs_read && avs_waitrequest && avs_address == 10'h1FF;
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> ack;
    endproperty
    a_ack: assert property (p_ack) else $error("request not acknowledged");
    property p_ack_pulse;
        ack |=> avs_waitrequest;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_pump_pair;
        pump_on == array_hv;
    endproperty
    a_pump_pair: assert property (p_pump_pair) else $error("pump mismatch");
    property p_hv_rise;
        $rose(array_hv) |-> $past(ctrl_wr && avs_writedata[3]);
    endproperty
    a_hv_rise: assert property (p_hv_rise) else $error("hv without write");
    property p_hv_clear;
        ctrl_wr && !avs_writedata[3] |=> !array_hv;
    endproperty
    a_hv_clear: assert property (p_hv_clear) else $error("hv not removed");
    property p_pwrdn;
        ctrl_wr && avs_writedata[4] |=> !pump_on;
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("pump on in power down");
    property p_clk_sel;
        $changed(pump_clk_bus) |-> $past(ctrl_wr)
            && pump_clk_bus == $past(avs_writedata[5]);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("pump clock select");
    property p_cfg_reload;
        $changed(mcu_config) && $past(rst_n, 2) |-> $past(cfg_rd)
            || $past(cfg_rd, 2);
    endproperty
    a_cfg_reload: assert property (p_cfg_reload) else $error("shadow changed");
    c_hv: cover property ($rose(array_hv));
    c_clk: cover property ($rose(pump_clk_bus));
    c_cfg: cover property (cfg_rd ##1 $changed(mcu_config));
endmodule : nv_ctrl_props

// [verification/nv_cpu_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Bus master standing in for software
// ----------------------------------------
module nv_cpu_model (
    input wire logic         ref_clk,
    input wire logic         avs_waitrequest,
    output logic      [9:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic             hang
);
    // bench bus clock is 50 MHz, so the bus may drive the pump
    initial begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        hang = 1'b0;
    end
    // Request held until waitrequest is sampled low
    task automatic xfer(input logic r, input logic [9:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= r;
        avs_write <= !r;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (avs_waitrequest) hang <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~avs_writedata;
    endtask : xfer
endmodule : nv_cpu_model

// [verification/nv_ctrl_tb.sv]
`timescale 1ns/1ns
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
    end end
module nv_ctrl_tb;
    localparam logic [9:0] CR = nv_ctrl_pkg::CTRL_IDX;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest, hang;
    logic        pump_on, pump_clk_bus, array_hv;
    logic [31:0] avs_writedata, avs_readdata, e_r;
    logic [1:0]  mcu_config;
    logic [31:0] exp_q[$];
    logic [8:0]  a;
    logic [7:0]  d, d2;
    int          error_cnt = 0, samples_checked = 0, seed = 17;
    always #10 ref_clk = ~ref_clk;
    nv_ctrl u_nv_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pump_on(pump_on), .pump_clk_bus(pump_clk_bus),
        .array_hv(array_hv), .mcu_config(mcu_config));
    nv_cpu_model u_nv_cpu_model (.ref_clk(ref_clk),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .hang(hang));
    task automatic rd(input logic [9:0] ad, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        u_nv_cpu_model.xfer(1'b1, ad, 8'h00);
    endtask : rd
    task automatic wr(input logic [9:0] ad, input logic [7:0] v);
        u_nv_cpu_model.xfer(1'b0, ad, v);
    endtask : wr
    // latch, write, voltage on, off, latch off
    task automatic op(input logic [1:0] s, input logic [8:0] ad,
                      input logic [7:0] v, input logic hv);
        wr(CR, {6'h01, s});
        wr({1'b0, ad}, v);
        wr(CR, {6'h03, s});
        @(negedge ref_clk);
        `CHK("array_hv", hv, array_hv)
        wr(CR, {6'h00, s});
        rd(CR, {5'h00, hv, s});
        wr(CR, {6'h00, s});
    endtask : op
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        if (avs_read && !avs_waitrequest) begin
            e_r = exp_q.pop_front();
            `CHK("avs_readdata", e_r, avs_readdata)
        end
        if (hang) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(CR, 8'h00);
        op(2'h1, 9'h1FF, 8'h00, 1'b1);
        op(2'h0, 9'h1FF, 8'hE0, 1'b1);
        rd(10'h1FF, 8'hE0);
        a = {2'b00, 7'($random(seed))};
        d = 8'($random(seed));
        d2 = 8'($random(seed));
        op(2'h1, a, 8'h00, 1'b1);
        op(2'h0, a, d, 1'b1);
        rd({1'b0, a}, d);
        op(2'h0, a, d2, 1'b1);
        rd({1'b0, a}, d & d2);
        wr(CR, 8'h04);
        wr(CR, 8'h0C);
        rd(CR, 8'h04);
        wr({1'b0, a}, 8'h11);
        wr({1'b0, a + 9'h001}, 8'h22);
        rd(10'h050, 8'h22);
        wr(CR, 8'h0C);
        wr(CR, 8'h0F);
        rd(CR, 8'h0C);
        wr(CR, 8'h00);
        wr(CR, 8'h00);
        wr(10'h3FF, 8'h5A);
        wr(CR, 8'h08);
        @(negedge ref_clk);
        `CHK("array_hv", 1'b0, array_hv)
        rd(10'h3FF, 8'h00);
        op(2'h1, 9'h1FF, 8'h00, 1'b1);
        op(2'h0, 9'h1FF, 8'hE1, 1'b1);
        rd(10'h1FF, 8'hE1);
        @(negedge ref_clk);
        `CHK("mcu_config", 2'b11, mcu_config)
        op(2'h0, 9'h010, 8'h00, 1'b0);
        op(2'h3, 9'h100, 8'h00, 1'b0);
        op(2'h2, 9'h085, 8'h00, 1'b1);
        rd(10'h0C0, 8'hFF);
        rd(10'h1FF, 8'hE1);
        wr(CR, 8'h20);
        @(negedge ref_clk);
        `CHK("pump_clk_bus", 1'b1, pump_clk_bus)
        end_of_test();
    end
endmodule : nv_ctrl_tb
bind nv_ctrl nv_ctrl_props u_nv_ctrl_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pump_on(pump_on), .pump_clk_bus(pump_clk_bus),
    .array_hv(array_hv), .mcu_config(mcu_config));
